// ### shared/bqc_pkg.sv
package bqc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // frame header codes
  localparam logic [7:0] BQC_TYPE_FRAME = 8'hC0;
  localparam logic [7:0] BQC_GROUP      = 8'h0E;
  localparam logic [7:0] BQC_ID_PEER    = 8'h08;
  localparam logic [7:0] BQC_ID_RSSI    = 8'h09;
  localparam logic [7:0] BQC_ID_SET     = 8'h0A;
  localparam logic [7:0] BQC_ID_GET     = 8'h0B;

  ////////////////////////////////////////////////////////////////////////////
  // payload lengths
  localparam logic [7:0] BQC_LEN_PEER_CMD = 8'h01;
  localparam logic [7:0] BQC_LEN_PEER_RSP = 8'h09;
  localparam logic [7:0] BQC_LEN_RSSI_CMD = 8'h01;
  localparam logic [7:0] BQC_LEN_RSSI_RSP = 8'h02;
  localparam logic [7:0] BQC_LEN_SET_CMD  = 8'h04;
  localparam logic [7:0] BQC_LEN_SET_RSP  = 8'h02;
  localparam logic [7:0] BQC_LEN_GET_CMD  = 8'h00;
  localparam logic [7:0] BQC_LEN_GET_RSP  = 8'h06;

  ////////////////////////////////////////////////////////////////////////////
  // frame geometry
  localparam int         BQC_HDR_BYTES  = 4;
  localparam int         BQC_CMD_PAY    = 4;
  localparam int         BQC_RSP_PAY    = 9;
  localparam int         BQC_RSP_FRAME  = 13;
  localparam int         BQC_ADDR_BYTES = 6;
  localparam logic [7:0] BQC_HDR_LAST   = 8'h03;
  localparam logic [7:0] BQC_ONE        = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // settings, factory defaults and codes
  localparam logic [7:0] BQC_DISC_DEF   = 8'h02;
  localparam logic [7:0] BQC_CONN_DEF   = 8'h01;
  localparam logic [7:0] BQC_FLAGS_DEF  = 8'h01;
  localparam logic [7:0] BQC_SNIFF_DEF  = 8'h01;
  localparam logic [7:0] BQC_LO_MASK    = 8'h0F;
  localparam int         BQC_FLAG_APPLY = 0;
  localparam logic [3:0] BQC_CONN_YES   = 4'h1;
  localparam logic [7:0] BQC_SNIFF_ON   = 8'h01;
  localparam logic [7:0] BQC_RES_OK     = 8'h00;
  localparam logic [7:0] BQC_RES_NOCONN = 8'h01;
  localparam logic [7:0] BQC_ZERO       = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // host register map
  localparam logic [7:0] BQC_REG_CTRL   = 8'h00;
  localparam logic [7:0] BQC_REG_PARAM  = 8'h04;
  localparam logic [7:0] BQC_REG_STATUS = 8'h08;
  localparam logic [7:0] BQC_REG_RSP0   = 8'h0C;
  localparam logic [7:0] BQC_REG_RSP1   = 8'h10;
  localparam logic [7:0] BQC_REG_RSP2   = 8'h14;
  localparam int         BQC_ST_DONE    = 1;

  typedef enum logic [1:0] {
    BQC_CMD_PEER = 2'b00,
    BQC_CMD_RSSI = 2'b01,
    BQC_CMD_SET  = 2'b10,
    BQC_CMD_GET  = 2'b11
  } bqc_cmd_t;

endpackage

// ### shared/bqc_link_if.sv
`timescale 1ns/100ps
interface bqc_link_if;
  logic [7:0] h2d_data;
  logic       h2d_valid;
  logic       h2d_ready;
  logic [7:0] d2h_data;
  logic       d2h_valid;
  logic       d2h_ready;
  modport dev  (input h2d_data, h2d_valid, d2h_ready,
                output h2d_ready, d2h_data, d2h_valid);
  modport host (output h2d_data, h2d_valid, d2h_ready,
                input h2d_ready, d2h_data, d2h_valid);
endinterface

// ### hdl/bqc_dev.sv
`timescale 1ns/100ps
// What this block does
// R01 - peer address query: C0, group 0E, len 01
// R02 - peer address answer: len 09, id 08
// R03 - signal strength query reports latest peer RSSI
// R04 - signal strength succeeds only while connected
// R05 - RSSI sent as signed two's complement byte
// R06 - signal strength: command len 01, answer 02
// R07 - set params: id 0A, four bytes, answer 02
// R08 - discoverable low nibble: default mode, default 2
// R09 - discoverable high nibble: connected mode, default 0
// R10 - host keeps both high nibbles at zero
// R11 - connectable low nibble: default, default 1
// R12 - second connection always refused
// R13 - flags bit 0 enables discoverable high nibble
// R14 - sniff byte permits idle sniff, default on
// R15 - host leaves sniff byte at default
// R16 - get params: id 0B, len 00, answer 06
// R17 - header order: type, length, group, id
module bqc_dev
  import bqc_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              nrst,
  bqc_link_if.dev                link,
  input  wire logic              link_up,
  input  wire logic [7:0]        link_handle,
  input  wire logic [47:0]       peer_addr,
  input  wire logic signed [7:0] rssi_dbm,
  output logic      [7:0]        disc_cfg,
  output logic      [7:0]        conn_cfg,
  output logic      [7:0]        flags_cfg,
  output logic      [7:0]        sniff_cfg,
  output logic      [3:0]        disc_mode,
  output logic                   accept_conn,
  output logic                   sniff_allow,
  output logic                   bad_frame
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {
    BQC_D_HDR  = 2'b00,
    BQC_D_PAY  = 2'b01,
    BQC_D_EXEC = 2'b10,
    BQC_D_TX   = 2'b11
  } bqc_dst_t;

  bqc_dst_t   st_ff;
  bqc_dst_t   nxt_st;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] hdr_ff [BQC_HDR_BYTES];
  logic [7:0] pay_ff [BQC_CMD_PAY];
  logic [7:0] rsp_ff [BQC_RSP_FRAME];
  logic [7:0] nxt_rsp [BQC_RSP_FRAME];
  logic [7:0] last_ff;
  logic [7:0] disc_ff;
  logic [7:0] conn_ff;
  logic [7:0] flags_ff;
  logic [7:0] sniff_ff;
  logic       bad_ff;

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire        rx_take  = link.h2d_valid && link.h2d_ready;
  wire        tx_take  = link.d2h_valid && link.d2h_ready;
  wire [7:0]  f_type   = hdr_ff[0];
  wire [7:0]  f_len    = hdr_ff[1];
  wire [7:0]  f_grp    = hdr_ff[2];
  wire [7:0]  f_id     = hdr_ff[3];
  wire        hdr_ok   = (f_type == BQC_TYPE_FRAME) && (f_grp == BQC_GROUP);
  wire        is_peer  = hdr_ok && f_id == BQC_ID_PEER
                         && f_len == BQC_LEN_PEER_CMD; // R01
  wire        is_rssi  = hdr_ok && f_id == BQC_ID_RSSI
                         && f_len == BQC_LEN_RSSI_CMD; // R06
  wire        is_set   = hdr_ok && f_id == BQC_ID_SET
                         && f_len == BQC_LEN_SET_CMD; // R07
  wire        is_get   = hdr_ok && f_id == BQC_ID_GET
                         && f_len == BQC_LEN_GET_CMD; // R16
  wire        known    = is_peer || is_rssi || is_set || is_get;
  wire        conn_ok  = link_up && (pay_ff[0] == link_handle); // R04
  wire [7:0]  result   = conn_ok ? BQC_RES_OK : BQC_RES_NOCONN;
  wire [7:0]  pay_last = f_len - BQC_ONE;
  wire        apply_hi = flags_ff[BQC_FLAG_APPLY]; // R13

  ////////////////////////////////////////////////////////////////////////////
  // response image
  always_comb begin
    for (int i = 0; i < BQC_RSP_FRAME; i++) begin
      nxt_rsp[i] = BQC_ZERO;
    end
    nxt_rsp[0] = BQC_TYPE_FRAME; // R17
    nxt_rsp[2] = BQC_GROUP;
    nxt_rsp[3] = f_id;
    nxt_rsp[4] = BQC_RES_OK;
    if (is_peer) begin
      nxt_rsp[1] = BQC_LEN_PEER_RSP; // R02
      nxt_rsp[4] = result;
      for (int i = 0; i < BQC_ADDR_BYTES; i++) begin
        nxt_rsp[5 + i] = conn_ok ? peer_addr[8 * i +: 8] : BQC_ZERO; // R02
      end
      nxt_rsp[11] = pay_ff[0];
    end else if (is_rssi) begin
      nxt_rsp[1] = BQC_LEN_RSSI_RSP; // R06
      nxt_rsp[4] = result;
      nxt_rsp[5] = conn_ok ? rssi_dbm : BQC_ZERO; // R03 R05
    end else if (is_set) begin
      nxt_rsp[1] = BQC_LEN_SET_RSP; // R07
    end else begin
      nxt_rsp[1] = BQC_LEN_GET_RSP; // R16
      nxt_rsp[6] = disc_ff;
      nxt_rsp[7] = conn_ff;
      nxt_rsp[8] = flags_ff;
      nxt_rsp[9] = sniff_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_comb begin
    nxt_st  = st_ff;
    nxt_cnt = cnt_ff;
    unique case (st_ff)
      BQC_D_HDR: begin
        if (rx_take) begin
          nxt_cnt = cnt_ff + BQC_ONE;
          if (cnt_ff == BQC_HDR_LAST) begin // R17
            nxt_cnt = BQC_ZERO;
            nxt_st  = (f_len == BQC_ZERO) ? BQC_D_EXEC : BQC_D_PAY;
          end
        end
      end
      BQC_D_PAY: begin
        if (rx_take) begin
          nxt_cnt = cnt_ff + BQC_ONE;
          if (cnt_ff == pay_last) begin
            nxt_cnt = BQC_ZERO;
            nxt_st  = BQC_D_EXEC;
          end
        end
      end
      BQC_D_EXEC: begin
        nxt_cnt = BQC_ZERO;
        nxt_st  = known ? BQC_D_TX : BQC_D_HDR;
      end
      BQC_D_TX: begin
        if (tx_take) begin
          nxt_cnt = cnt_ff + BQC_ONE;
          if (cnt_ff == last_ff) begin
            nxt_cnt = BQC_ZERO;
            nxt_st  = BQC_D_HDR;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff  <= BQC_D_HDR;
      cnt_ff <= BQC_ZERO;
      bad_ff <= 1'b0;
    end else begin
      st_ff  <= nxt_st;
      cnt_ff <= nxt_cnt;
      bad_ff <= (st_ff == BQC_D_EXEC) && !known;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // capture of incoming bytes
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BQC_HDR_BYTES; i++) begin
        hdr_ff[i] <= BQC_ZERO;
      end
      for (int i = 0; i < BQC_CMD_PAY; i++) begin
        pay_ff[i] <= BQC_ZERO;
      end
    end else if (rx_take) begin
      if (st_ff == BQC_D_HDR) begin
        hdr_ff[cnt_ff[1:0]] <= link.h2d_data;
      end else if (cnt_ff < BQC_CMD_PAY) begin
        pay_ff[cnt_ff[1:0]] <= link.h2d_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // response frame and settings
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BQC_RSP_FRAME; i++) begin
        rsp_ff[i] <= BQC_ZERO;
      end
      last_ff <= BQC_ZERO;
    end else if (st_ff == BQC_D_EXEC && known) begin
      for (int i = 0; i < BQC_RSP_FRAME; i++) begin
        rsp_ff[i] <= nxt_rsp[i];
      end
      last_ff <= nxt_rsp[1] + BQC_HDR_LAST;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      disc_ff  <= BQC_DISC_DEF; // R08 R09
      conn_ff  <= BQC_CONN_DEF; // R11
      flags_ff <= BQC_FLAGS_DEF; // R13
      sniff_ff <= BQC_SNIFF_DEF; // R14
    end else if (st_ff == BQC_D_EXEC && is_set) begin
      disc_ff  <= pay_ff[0]; // R07
      conn_ff  <= pay_ff[1];
      flags_ff <= pay_ff[2];
      sniff_ff <= pay_ff[3];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.h2d_ready = (st_ff == BQC_D_HDR) || (st_ff == BQC_D_PAY);
  assign link.d2h_valid = (st_ff == BQC_D_TX);
  assign link.d2h_data  = rsp_ff[cnt_ff[3:0]];
  assign disc_cfg    = disc_ff;
  assign conn_cfg    = conn_ff;
  assign flags_cfg   = flags_ff;
  assign sniff_cfg   = sniff_ff;
  assign disc_mode   = (link_up && apply_hi) ? disc_ff[7:4]
                                             : disc_ff[3:0]; // R08 R09
  assign accept_conn = !link_up && (conn_ff[3:0] == BQC_CONN_YES); // R11 R12
  assign sniff_allow = (sniff_ff == BQC_SNIFF_ON); // R14
  assign bad_frame   = bad_ff;

endmodule

// ### hdl/bqc_host.sv
`timescale 1ns/100ps
module bqc_host
  import bqc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        nrst,
  bqc_link_if.host         link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef enum logic [1:0] {
    BQC_H_IDLE = 2'b00,
    BQC_H_TX   = 2'b01,
    BQC_H_HDR  = 2'b10,
    BQC_H_PAY  = 2'b11
  } bqc_hst_t;

  bqc_hst_t   st_ff;
  logic [7:0] cnt_ff;
  logic [7:0] tx_ff [BQC_HDR_BYTES + BQC_CMD_PAY];
  logic [7:0] nxt_tx [BQC_HDR_BYTES + BQC_CMD_PAY];
  logic [7:0] tx_last_ff;
  logic [7:0] rsp_ff [BQC_RSP_PAY + 3];
  logic [7:0] rlen_ff;
  logic [7:0] rid_ff;
  logic [31:0] param_ff;
  logic       done_ff;

  ////////////////////////////////////////////////////////////////////////////
  // register decode
  wire        acc      = psel && penable;
  wire        wr       = acc && pwrite;
  wire        hit_ctrl = paddr == BQC_REG_CTRL;
  wire        hit_par  = paddr == BQC_REG_PARAM;
  wire        hit_st   = paddr == BQC_REG_STATUS;
  wire        hit_r0   = paddr == BQC_REG_RSP0;
  wire        hit_r1   = paddr == BQC_REG_RSP1;
  wire        hit_r2   = paddr == BQC_REG_RSP2;
  wire        hit      = hit_ctrl | hit_par | hit_st | hit_r0 | hit_r1 | hit_r2;
  wire        busy     = st_ff != BQC_H_IDLE;
  wire        start    = wr && hit_ctrl && !busy;
  wire bqc_cmd_t sel   = bqc_cmd_t'(pwdata[1:0]);
  wire [7:0]  handle   = pwdata[15:8];
  wire        tx_take  = link.h2d_valid && link.h2d_ready;
  wire        rx_take  = link.d2h_valid && link.d2h_ready;
  wire        rsp_end  = rx_take && (st_ff == BQC_H_PAY)
                         && (cnt_ff == rlen_ff - BQC_ONE);
  wire        rsp_nil  = rx_take && (st_ff == BQC_H_HDR)
                         && (cnt_ff == BQC_HDR_LAST) && (rlen_ff == BQC_ZERO);
  wire        clr_done = wr && hit_st && pwdata[BQC_ST_DONE];

  ////////////////////////////////////////////////////////////////////////////
  // command frame image
  always_comb begin
    for (int i = 0; i < BQC_HDR_BYTES + BQC_CMD_PAY; i++) begin
      nxt_tx[i] = BQC_ZERO;
    end
    nxt_tx[0] = BQC_TYPE_FRAME; // R17
    nxt_tx[2] = BQC_GROUP;
    nxt_tx[4] = handle;
    unique case (sel)
      BQC_CMD_PEER: begin
        nxt_tx[1] = BQC_LEN_PEER_CMD; // R01
        nxt_tx[3] = BQC_ID_PEER;
      end
      BQC_CMD_RSSI: begin
        nxt_tx[1] = BQC_LEN_RSSI_CMD; // R06
        nxt_tx[3] = BQC_ID_RSSI;
      end
      BQC_CMD_SET: begin
        nxt_tx[1] = BQC_LEN_SET_CMD; // R07
        nxt_tx[3] = BQC_ID_SET;
        nxt_tx[4] = param_ff[7:0] & BQC_LO_MASK; // R10
        nxt_tx[5] = param_ff[15:8] & BQC_LO_MASK; // R10
        nxt_tx[6] = param_ff[23:16];
        nxt_tx[7] = BQC_SNIFF_DEF; // R15
      end
      BQC_CMD_GET: begin
        nxt_tx[1] = BQC_LEN_GET_CMD; // R16
        nxt_tx[3] = BQC_ID_GET;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequencing
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_ff  <= BQC_H_IDLE;
      cnt_ff <= BQC_ZERO;
    end else if (start) begin
      st_ff  <= BQC_H_TX;
      cnt_ff <= BQC_ZERO;
    end else if (tx_take) begin
      cnt_ff <= cnt_ff + BQC_ONE;
      if (cnt_ff == tx_last_ff) begin
        st_ff  <= BQC_H_HDR;
        cnt_ff <= BQC_ZERO;
      end
    end else if (rx_take) begin
      cnt_ff <= cnt_ff + BQC_ONE;
      if (rsp_end || rsp_nil) begin
        st_ff  <= BQC_H_IDLE;
        cnt_ff <= BQC_ZERO;
      end else if (st_ff == BQC_H_HDR && cnt_ff == BQC_HDR_LAST) begin
        st_ff  <= BQC_H_PAY;
        cnt_ff <= BQC_ZERO;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BQC_HDR_BYTES + BQC_CMD_PAY; i++) begin
        tx_ff[i] <= BQC_ZERO;
      end
      tx_last_ff <= BQC_ZERO;
    end else if (start) begin
      for (int i = 0; i < BQC_HDR_BYTES + BQC_CMD_PAY; i++) begin
        tx_ff[i] <= nxt_tx[i];
      end
      tx_last_ff <= nxt_tx[1] + BQC_HDR_LAST;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < BQC_RSP_PAY + 3; i++) begin
        rsp_ff[i] <= BQC_ZERO;
      end
      rlen_ff <= BQC_ZERO;
      rid_ff  <= BQC_ZERO;
    end else if (rx_take) begin
      if (st_ff == BQC_H_HDR && cnt_ff == BQC_ONE) begin
        rlen_ff <= link.d2h_data;
      end
      if (st_ff == BQC_H_HDR && cnt_ff == BQC_HDR_LAST) begin
        rid_ff <= link.d2h_data;
      end
      if (st_ff == BQC_H_PAY && cnt_ff < BQC_RSP_PAY) begin
        rsp_ff[cnt_ff[3:0]] <= link.d2h_data;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      param_ff <= {BQC_SNIFF_DEF, BQC_FLAGS_DEF, BQC_CONN_DEF, BQC_DISC_DEF};
      done_ff  <= 1'b0;
    end else begin
      if (wr && hit_par) begin
        param_ff <= pwdata;
      end
      if (rsp_end || rsp_nil) begin
        done_ff <= 1'b1;
      end else if (clr_done) begin
        done_ff <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign link.h2d_valid = (st_ff == BQC_H_TX);
  assign link.h2d_data  = tx_ff[cnt_ff[2:0]];
  assign link.d2h_ready = (st_ff == BQC_H_HDR) || (st_ff == BQC_H_PAY);
  assign pready  = 1'b1;
  assign pslverr = acc && !hit;
  assign prdata  = hit_par  ? param_ff :
                   hit_st   ? {8'h00, rlen_ff, rid_ff, 6'h00, done_ff, busy} :
                   hit_r0   ? {rsp_ff[3], rsp_ff[2], rsp_ff[1], rsp_ff[0]} :
                   hit_r1   ? {rsp_ff[7], rsp_ff[6], rsp_ff[5], rsp_ff[4]} :
                   hit_r2   ? {24'h000000, rsp_ff[8]} : 32'h00000000;

endmodule

// ### bench/bqc_assertions.sv
`timescale 1ns/100ps
module bqc_chk (
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic [7:0] h2d_data,
  input wire logic       h2d_valid,
  input wire logic       h2d_ready,
  input wire logic [7:0] d2h_data,
  input wire logic       d2h_valid,
  input wire logic       d2h_ready
);
  logic [7:0] h_idx_ff;
  logic [7:0] h_len_ff;
  logic [7:0] h_id_ff;
  logic [7:0] d_idx_ff;
  logic [7:0] d_len_ff;
  wire        h_take = h2d_valid && h2d_ready;
  wire        d_take = d2h_valid && d2h_ready;
  wire        h_end  = h_take && h_idx_ff >= 8'h03 &&
                       h_idx_ff == h_len_ff + 8'h03;
  wire        d_end  = d_take && d_idx_ff >= 8'h03 &&
                       d_idx_ff == d_len_ff + 8'h03;

  ////////////////////////////////////////////////////////////////////////////
  // byte position trackers
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      h_idx_ff <= 8'h00;
      h_len_ff <= 8'h00;
      h_id_ff  <= 8'h00;
      d_idx_ff <= 8'h00;
      d_len_ff <= 8'h00;
    end else begin
      if (h_take) h_idx_ff <= h_end ? 8'h00 : h_idx_ff + 8'h01;
      if (h_take && h_idx_ff == 8'h01) h_len_ff <= h2d_data;
      if (h_take && h_idx_ff == 8'h03) h_id_ff <= h2d_data;
      if (d_take) d_idx_ff <= d_end ? 8'h00 : d_idx_ff + 8'h01;
      if (d_take && d_idx_ff == 8'h01) d_len_ff <= d2h_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  a_cmd_type_first: assert property (h_take && h_idx_ff == 8'h00 |->
    h2d_data == 8'hC0) else $error("command type byte wrong");
  a_cmd_group: assert property (h_take && h_idx_ff == 8'h02 |->
    h2d_data == 8'h0E) else $error("command group byte wrong");
  a_cmd_len_match: assert property (h_take && h_idx_ff == 8'h03 |->
    h_len_ff == (h2d_data == 8'h0A ? 8'h04 :
                 h2d_data == 8'h0B ? 8'h00 : 8'h01))
    else $error("command length does not fit id");
  a_rsp_type_first: assert property (d_take && d_idx_ff == 8'h00 |->
    d2h_data == 8'hC0) else $error("response type byte wrong");
  a_rsp_group: assert property (d_take && d_idx_ff == 8'h02 |->
    d2h_data == 8'h0E) else $error("response group byte wrong");
  a_rsp_id_echo: assert property (d_take && d_idx_ff == 8'h03 |->
    d2h_data == h_id_ff) else $error("response id differs from command");
  a_peer_rsp_len: assert property (d_take && d_idx_ff == 8'h03 &&
    d2h_data == 8'h08 |-> d_len_ff == 8'h09)
    else $error("peer answer length wrong");
  a_short_rsp_len: assert property (d_take && d_idx_ff == 8'h03 &&
    (d2h_data == 8'h09 || d2h_data == 8'h0A) |-> d_len_ff == 8'h02)
    else $error("short answer length wrong");
  a_get_rsp_len: assert property (d_take && d_idx_ff == 8'h03 &&
    d2h_data == 8'h0B |-> d_len_ff == 8'h06)
    else $error("settings answer length wrong");
  a_answer_soon: assert property (h_end |-> ##[1:3] d2h_valid)
    else $error("no answer after command");
  a_rx_closed: assert property (d2h_valid |-> !h2d_ready)
    else $error("receiving while answering");

  c_peer: cover property (d_end && h_id_ff == 8'h08);
  c_rssi: cover property (d_end && h_id_ff == 8'h09);
  c_set:  cover property (d_end && h_id_ff == 8'h0A);
  c_get:  cover property (d_end && h_id_ff == 8'h0B);
endmodule

// ### bench/test_bredr_query_config_commands.sv
`timescale 1ns/100ps
module test_bredr_query_config_commands;
  import bqc_pkg::*;
  logic        core_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        link_up = 1'b0;
  logic [7:0]  link_handle = 8'h05;
  logic [47:0] peer_addr = 48'hA5A4A3A2A1A0;
  logic signed [7:0] rssi_dbm = 8'sh00;
  logic [7:0]  disc_cfg, conn_cfg, flags_cfg, sniff_cfg;
  logic [3:0]  disc_mode;
  logic        accept_conn, sniff_allow, bad_frame;
  logic [31:0] rdat, r0, r1, r2;
  logic        rerr;
  int          n_errors = 0;
  int          n_compared = 0;
  int          n_bad = 0;

  always #20 core_clk = ~core_clk;

  // malformed frame pulses seen by the device
  always @(posedge core_clk) begin
    if (nrst === 1'b1 && bad_frame !== 1'b0) begin
      n_bad++;
    end
  end

  bqc_link_if link ();
  bqc_dev bqc_dev_inst (.core_clk(core_clk), .nrst(nrst), .link(link),
    .link_up(link_up), .link_handle(link_handle), .peer_addr(peer_addr),
    .rssi_dbm(rssi_dbm), .disc_cfg(disc_cfg), .conn_cfg(conn_cfg),
    .flags_cfg(flags_cfg), .sniff_cfg(sniff_cfg), .disc_mode(disc_mode),
    .accept_conn(accept_conn), .sniff_allow(sniff_allow),
    .bad_frame(bad_frame));
  bqc_host bqc_host_inst (.core_clk(core_clk), .nrst(nrst), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  bqc_chk bqc_chk_inst (.core_clk(core_clk), .nrst(nrst),
    .h2d_data(link.h2d_data), .h2d_valid(link.h2d_valid),
    .h2d_ready(link.h2d_ready), .d2h_data(link.d2h_data),
    .d2h_valid(link.d2h_valid), .d2h_ready(link.d2h_ready));

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int i;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // access phase: answer taken at the edge that sees pready high
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (pready === 1'b1 && psel === 1'b1 && penable === 1'b1) break;
    end
    if (i == 50) begin
      n_errors++;
      close_out();
    end
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_cmd(input logic [1:0] cmd, input logic [7:0] hnd,
                         input logic [7:0] id, input logic [7:0] len);
    int i;
    apb(1'b1, BQC_REG_CTRL, {16'h0000, hnd, 6'h00, cmd});
    for (i = 0; i < 100; i++) begin
      apb(1'b0, BQC_REG_STATUS, 32'h0);
      if (i == 0) begin
        chk({31'h0, rdat[0]}, 32'h1);
      end
      if (rdat[1] === 1'b1) break;
    end
    if (i == 100) begin
      n_errors++;
      close_out();
    end
    chk({8'h0, rdat[23:8], 6'h0, rdat[1:0]}, {8'h0, len, id, 8'h02});
    apb(1'b0, BQC_REG_RSP0, 32'h0);
    r0 = rdat;
    apb(1'b0, BQC_REG_RSP1, 32'h0);
    r1 = rdat;
    apb(1'b0, BQC_REG_RSP2, 32'h0);
    r2 = rdat;
    apb(1'b1, BQC_REG_STATUS, 32'h2);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_defaults;
    apb(1'b0, BQC_REG_PARAM, 32'h0);
    chk(rdat, 32'h01010102);
    chk({disc_cfg, conn_cfg, flags_cfg, sniff_cfg}, 32'h02010101);
    chk({26'h0, disc_mode, accept_conn, sniff_allow}, 32'h0000000B);
    run_cmd(BQC_CMD_GET, 8'h00, 8'h0B, 8'h06);
    chk(r0, 32'h01020000);
    chk({16'h0, r1[15:0]}, 32'h00000101);
  endtask

  task automatic t_peer;
    run_cmd(BQC_CMD_PEER, 8'h05, 8'h08, 8'h09);
    chk({24'h0, r0[7:0]}, 32'h00000001);
    link_up <= 1'b1;
    run_cmd(BQC_CMD_PEER, 8'h05, 8'h08, 8'h09);
    chk(r0, 32'hA2A1A000);
    chk(r1, 32'h05A5A4A3);
    chk({24'h0, r2[7:0]}, 32'h0);
  endtask

  task automatic t_rssi;
    logic [7:0] vals [3] = '{8'hF0, 8'h03, 8'hFF};
    foreach (vals[k]) begin
      rssi_dbm <= vals[k];
      run_cmd(BQC_CMD_RSSI, 8'h05, 8'h09, 8'h02);
      chk({16'h0, r0[15:0]}, {16'h0, vals[k], 8'h00});
    end
    run_cmd(BQC_CMD_RSSI, 8'h06, 8'h09, 8'h02);
    chk({16'h0, r0[15:0]}, 32'h00000001);
    link_up <= 1'b0;
    run_cmd(BQC_CMD_RSSI, 8'h05, 8'h09, 8'h02);
    chk({16'h0, r0[15:0]}, 32'h00000001);
  endtask

  task automatic t_set_get;
    apb(1'b1, BQC_REG_PARAM, 32'hFF001021);
    run_cmd(BQC_CMD_SET, 8'h00, 8'h0A, 8'h02);
    chk({16'h0, r0[15:0]}, 32'h0);
    chk({disc_cfg, conn_cfg, flags_cfg, sniff_cfg}, 32'h01000001);
    chk({27'h0, disc_mode, accept_conn}, 32'h00000002);
    apb(1'b1, BQC_REG_PARAM, 32'h00010102);
    link_up <= 1'b1;
    run_cmd(BQC_CMD_SET, 8'h00, 8'h0A, 8'h02);
    chk({27'h0, disc_mode, accept_conn}, 32'h0);
    run_cmd(BQC_CMD_GET, 8'h00, 8'h0B, 8'h06);
    chk(r0, 32'h01020000);
    chk({16'h0, r1[15:0]}, 32'h00000101);
    apb(1'b1, BQC_REG_PARAM, 32'h00000102);
    run_cmd(BQC_CMD_SET, 8'h00, 8'h0A, 8'h02);
    chk({27'h0, disc_mode, accept_conn}, 32'h00000004);
    chk({31'h0, sniff_allow}, 32'h1);
  endtask

  task automatic t_unmapped;
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    chk({31'h0, rerr}, 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rdat, 32'h0);
    apb(1'b0, BQC_REG_PARAM, 32'h0);
    chk(rdat, 32'h00000102);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence and watchdog
  initial begin
    repeat (20) @(posedge core_clk);
    nrst <= 1'b1;
    t_defaults();
    t_peer();
    t_rssi();
    t_set_get();
    t_unmapped();
    chk(n_bad, 32'h0);
    close_out();
  end

  initial begin
    repeat (40000) @(posedge core_clk);
    n_errors++;
    close_out();
  end
endmodule
